// ### core/pmx_bus_seq.sv
// Device-side sequencer: select watchdog, sleep/wake, latency and burst read data
`timescale 1ns/1ns
module pmx_bus_seq
  import pmx_pkg::*;
#(
  parameter int unsigned MAX_LOW_CYC  = pmx_pkg::MAX_SELECT_LOW_CYC,
  parameter int unsigned ENTRY_CYC    = pmx_pkg::SLEEP_ENTRY_HOLD_CYC,
  parameter int unsigned EXIT_CYC     = pmx_pkg::SLEEP_EXIT_PULSE_CYC,
  parameter int unsigned WAKE_CYC     = pmx_pkg::WAKE_READY_CYC,
  parameter int unsigned BURST_LEN    = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     link_clk,
  input  wire logic                     chipSelect_n,
  input  wire logic                     addr_valid_n,
  input  wire logic                     writeEnable_n,
  input  wire logic                     cfgWrite,
  input  wire logic [pmx_pkg::CFG_W-1:0] cfgData,
  input  wire logic [15:0]              readData,
  output logic                          waitOut,
  output logic [15:0]                   adqOut,
  output logic                          adqOe,
  output logic [pmx_pkg::CFG_W-1:0]     bus_config_reg,
  output logic                          deepSleep,
  output logic                          ready,
  output logic                          selectTimeout,
  output logic                          writeTimeout,
  output logic                          gapViolation
);
  import pmx_pkg::*;

  // ==========================================
  // Pin synchronisers into core domain
  logic [2:0] syncA_q, syncB_q;
  always_ff @(posedge core_clk) begin
    syncA_q <= {chipSelect_n, writeEnable_n, cfgWrite};
    syncB_q <= syncA_q;
  end
  logic selN, weN, cfgWr, selPrev_q, cfgPrev_q;
  assign selN  = syncB_q[2];
  assign weN   = syncB_q[1];
  assign cfgWr = syncB_q[0];

  // ==========================================
  // Watchdogs, gap check and config register
  logic [31:0] lowCnt_q, lowCnt_d, weCnt_q, weCnt_d, highCnt_q, highCnt_d;
  logic selTo_d, selTo_q, wTo_d, wTo_q, gap_d, gap_q;
  logic [CFG_W-1:0] cfg_d, cfg_q;
  pmx_power_t pwr_q, pwr_d;
  logic [31:0] pCnt_q, pCnt_d;
  logic wakeDone;
  assign wakeDone = (pwr_q == PMX_WAKE) && (pCnt_q >= WAKE_CYC - 1);
  always_comb begin
    lowCnt_d  = selN ? 32'h0 : lowCnt_q + 32'h1;
    weCnt_d   = weN ? 32'h0 : weCnt_q + 32'h1;
    highCnt_d = selN ? highCnt_q + 32'h1 : 32'h0;
    selTo_d   = selTo_q | (lowCnt_q >= MAX_LOW_CYC);
    wTo_d     = wTo_q | (weCnt_q >= MAX_LOW_CYC);
    // Rising select edge already counts as a clocked high
    gap_d     = gap_q | (!selN && selPrev_q && highCnt_q < GAP_CYC);
    cfg_d     = (cfgWr && !cfgPrev_q) ? cfgData : cfg_q;
    // Wake reloads the defaults, so sleep is not re-entered at once
    if (wakeDone) cfg_d = CFG_RESET;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lowCnt_q  <= 32'h0;
      weCnt_q   <= 32'h0;
      // Counts as a full gap so a low select at release is no false flag
      highCnt_q <= 32'(GAP_CYC);
      selTo_q   <= 1'b0;
      wTo_q     <= 1'b0;
      gap_q     <= 1'b0;
      cfg_q     <= CFG_RESET;
      selPrev_q <= 1'b1;
      cfgPrev_q <= 1'b0;
    end else begin
      lowCnt_q  <= lowCnt_d;
      weCnt_q   <= weCnt_d;
      highCnt_q <= highCnt_d;
      selTo_q   <= selTo_d;
      wTo_q     <= wTo_d;
      gap_q     <= gap_d;
      cfg_q     <= cfg_d;
      selPrev_q <= selN;
      cfgPrev_q <= cfgWr;
    end
  end

  // ==========================================
  // Deep sleep sequencing
  always_comb begin
    pwr_d  = pwr_q;
    pCnt_d = pCnt_q + 32'h1;
    case (pwr_q)
      PMX_ACTIVE: begin
        pCnt_d = 32'h0;
        if (!cfg_q[SLEEP_BIT] && selN) pwr_d = PMX_ENTRY;
      end
      PMX_ENTRY: begin
        if (!selN || cfg_q[SLEEP_BIT]) begin
          pwr_d  = PMX_ACTIVE;
          pCnt_d = 32'h0;
        end else if (pCnt_q >= ENTRY_CYC - 1) begin
          pwr_d  = PMX_SLEEP;
          pCnt_d = 32'h0;
        end
      end
      PMX_SLEEP: begin
        if (selN) pCnt_d = 32'h0;
        else if (pCnt_q >= EXIT_CYC - 1) begin
          pwr_d  = PMX_WAKE;
          pCnt_d = 32'h0;
        end
      end
      PMX_WAKE: begin
        if (pCnt_q >= WAKE_CYC - 1) begin
          pwr_d  = PMX_ACTIVE;
          pCnt_d = 32'h0;
        end
      end
      default: pwr_d = PMX_ACTIVE;
    endcase
  end
  logic [CFG_W-1:0] cfgOut_d;
  always_comb begin
    cfgOut_d = cfg_q;
    if (wakeDone) cfgOut_d = CFG_RESET;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pwr_q          <= PMX_ACTIVE;
      pCnt_q         <= 32'h0;
      deepSleep      <= 1'b0;
      ready          <= 1'b1;
      selectTimeout  <= 1'b0;
      writeTimeout   <= 1'b0;
      gapViolation   <= 1'b0;
      bus_config_reg <= CFG_RESET;
    end else begin
      pwr_q          <= pwr_d;
      pCnt_q         <= pCnt_d;
      deepSleep      <= (pwr_d == PMX_SLEEP);
      ready          <= (pwr_d == PMX_ACTIVE);
      selectTimeout  <= selTo_q;
      writeTimeout   <= wTo_q;
      gapViolation   <= gap_q;
      bus_config_reg <= cfgOut_d;
    end
  end

  // ==========================================
  // Link domain: latency and burst read data
  logic [1:0] lnkRst_q, lnkRdy_q;
  logic [2:0] lat_q;
  always_ff @(posedge link_clk) begin
    lnkRst_q <= {lnkRst_q[0], reset_n};
    lnkRdy_q <= {lnkRdy_q[0], ready};
  end
  always_ff @(posedge link_clk) begin
    // Captured at the address latch; config is static across a frame
    if (!addr_valid_n) lat_q <= bus_config_reg[LAT_MSB:LAT_LSB];
  end
  logic [7:0] beat_q, beat_d;
  logic waitO_d, oe_d;
  logic [15:0] adq_d;
  logic [7:0] latClk;
  assign latClk = {5'h0, lat_q} + 8'h1;
  always_comb begin
    beat_d  = beat_q;
    waitO_d = 1'b0;
    oe_d    = 1'b0;
    adq_d   = 16'h0;
    // Address latch edge restarts the count with the bus idle
    if (chipSelect_n || !addr_valid_n || !lnkRdy_q[1]) beat_d = 8'h0;
    else begin
      if (beat_q != 8'hff) beat_d = beat_q + 8'h1;
      if (beat_q < {5'h0, lat_q}) waitO_d = 1'b1;
      else if (beat_q >= latClk - 8'h1) begin
        oe_d  = 1'b1;
        adq_d = (beat_q < latClk - 8'h1 + 8'(BURST_LEN)) ? readData
                                                         : UNDEF_WORD;
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (!lnkRst_q[1]) begin
      beat_q  <= 8'h0;
      waitOut <= 1'b0;
      adqOut  <= 16'h0;
      adqOe   <= 1'b0;
    end else begin
      beat_q  <= beat_d;
      waitOut <= waitO_d;
      adqOut  <= adq_d;
      adqOe   <= oe_d;
    end
  end

  // ==========================================
  // Checks
  sequence SEQ_LOW_LONG;
    lowCnt_q >= MAX_LOW_CYC;
  endsequence
  AST_SELECT_TO: assert property (@(posedge core_clk) disable iff (!reset_n)
    SEQ_LOW_LONG |-> ##2 selectTimeout) else $error("select timeout missed");
  AST_WRITE_TO: assert property (@(posedge core_clk) disable iff (!reset_n)
    weCnt_q >= MAX_LOW_CYC |-> ##2 writeTimeout) else $error("write timeout missed");
  AST_DRIVE: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> bus_config_reg[DRIVE_MSB:DRIVE_LSB] == DRIVE_HALF)
    else $error("drive default wrong");
  AST_ENTRY: assert property (@(posedge core_clk) disable iff (!reset_n)
    pwr_q == PMX_ENTRY && pwr_d == PMX_SLEEP |-> pCnt_q == ENTRY_CYC - 1)
    else $error("sleep entered early");
  AST_EXIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    pwr_q == PMX_SLEEP && pwr_d == PMX_WAKE |-> !selN && pCnt_q == EXIT_CYC - 1)
    else $error("wake pulse wrong");
  AST_READY: assert property (@(posedge core_clk) disable iff (!reset_n)
    pwr_q == PMX_WAKE |-> !ready) else $error("ready during wake");
  AST_GAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    !selN && selPrev_q && highCnt_q < GAP_CYC |-> ##2 gapViolation)
    else $error("gap not flagged");
  AST_WAIT: assert property (@(posedge link_clk) disable iff (!lnkRst_q[1])
    waitOut |-> $past(beat_q) < {5'h0, lat_q}) else $error("wait too long");
  AST_UNDEF: assert property (@(posedge link_clk) disable iff (!lnkRst_q[1])
    adqOe && $past(beat_q) >= {5'h0, lat_q} + 8'(BURST_LEN) |-> adqOut == UNDEF_WORD)
    else $error("data past burst end not undefined");
  AST_OE_WAIT: assert property (@(posedge link_clk) disable iff (!lnkRst_q[1])
    adqOe |-> !waitOut) else $error("wait with data");
endmodule : pmx_bus_seq

// ### core/pmx_pkg.sv
// Shared constants for the muxed pseudo-static RAM bus sequencer
package pmx_pkg;
  localparam int unsigned CORE_CLK_MHZ        = 100;
  localparam int unsigned LINK_CLK_NS          = 30;
  // Timing figures in their own units
  localparam int unsigned MAX_SELECT_LOW_US    = 4;
  localparam int unsigned REFRESH_HIGH_NS      = 15;
  localparam int unsigned BURST_GAP_NS         = 5;
  localparam int unsigned ASYNC_GAP_NS         = 5;
  localparam int unsigned SLEEP_ENTRY_HOLD_US  = 150;
  localparam int unsigned SLEEP_EXIT_PULSE_US  = 10;
  localparam int unsigned WAKE_READY_US        = 150;
  localparam int unsigned SETUP_LIMIT_NS       = 20;
  // Derived cycle counts at the core clock
  localparam int unsigned MAX_SELECT_LOW_CYC   = MAX_SELECT_LOW_US * CORE_CLK_MHZ;
  localparam int unsigned REFRESH_HIGH_CYC     = (REFRESH_HIGH_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC_RAW          = (BURST_GAP_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned GAP_CYC              = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
  localparam int unsigned SLEEP_ENTRY_HOLD_CYC = SLEEP_ENTRY_HOLD_US * CORE_CLK_MHZ;
  localparam int unsigned SLEEP_EXIT_PULSE_CYC = SLEEP_EXIT_PULSE_US * CORE_CLK_MHZ;
  localparam int unsigned WAKE_READY_CYC       = WAKE_READY_US * CORE_CLK_MHZ;
  // Configuration register layout
  localparam int unsigned CFG_W                = 16;
  localparam int unsigned LAT_LSB              = 11;
  localparam int unsigned LAT_MSB              = 13;
  localparam int unsigned DRIVE_LSB            = 4;
  localparam int unsigned DRIVE_MSB            = 5;
  localparam int unsigned SLEEP_BIT            = 4;
  localparam logic [15:0] CFG_RESET            = 16'h1510;
  localparam logic [1:0]  DRIVE_HALF           = 2'h1;
  localparam logic [15:0] UNDEF_WORD           = 16'hdead;
  typedef enum {PMX_ACTIVE, PMX_ENTRY, PMX_SLEEP, PMX_WAKE} pmx_power_t;
endpackage : pmx_pkg

// ### verif/pmx_ctl_model.sv
// Memory-controller model driving select, latch, write enable and burst clock
`timescale 1ns/1ns
module pmx_ctl_model;
  logic link_clk      = 1'b0;
  logic chipSelect_n  = 1'b1;
  logic addr_valid_n  = 1'b1;
  logic writeEnable_n = 1'b1;
  logic run           = 1'b0;
  // Burst clock stands still outside frames, except while the testbench reset sequence drives run high
  always #15 link_clk = run ? ~link_clk : 1'b0;
  task automatic frame(input int lowCyc, input logic wr);
    chipSelect_n  = 1'b0;
    addr_valid_n  = 1'b0;
    writeEnable_n = ~wr;
    run           = 1'b1;
    @(posedge link_clk);
    #1 addr_valid_n = 1'b1;
    repeat (lowCyc - 1) @(posedge link_clk);
    #1 chipSelect_n = 1'b1;
    writeEnable_n = 1'b1;
    // One clocked high edge lets the device close the frame
    @(posedge link_clk);
    #1 run        = 1'b0;
    #25;
  endtask : frame
endmodule : pmx_ctl_model

// ### verif/tb.sv
// Testbench for the muxed bus sequencer
`timescale 1ns/1ns
module tb;
  import pmx_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        cfgWrite = 1'b0;
  logic [15:0] cfgData  = CFG_RESET;
  logic [15:0] readData = 16'h5a3c;
  logic        waitOut, adqOe, deepSleep, ready, selectTimeout, writeTimeout, gapViolation;
  logic [15:0] adqOut, bus_config_reg;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  pmx_ctl_model m();
  pmx_bus_seq #(.MAX_LOW_CYC(40), .ENTRY_CYC(50), .EXIT_CYC(20), .WAKE_CYC(50)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(m.link_clk),
    .chipSelect_n(m.chipSelect_n), .addr_valid_n(m.addr_valid_n),
    .writeEnable_n(m.writeEnable_n), .cfgWrite(cfgWrite), .cfgData(cfgData),
    .readData(readData), .waitOut(waitOut), .adqOut(adqOut), .adqOe(adqOe),
    .bus_config_reg(bus_config_reg), .deepSleep(deepSleep), .ready(ready),
    .selectTimeout(selectTimeout), .writeTimeout(writeTimeout),
    .gapViolation(gapViolation));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic wait_core(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_core
  task automatic do_reset;
    reset_n = 1'b0;
    m.run   = 1'b1;
    wait_core(10);
    reset_n = 1'b1;
    // Link reset synchroniser needs edges after release
    wait_core(10);
    m.run   = 1'b0;
    wait_core(4);
  endtask : do_reset
  task automatic load_cfg(input logic [15:0] v);
    cfgData  = v;
    cfgWrite = 1'b1;
    wait_core(4);
    cfgWrite = 1'b0;
    wait_core(4);
  endtask : load_cfg
  task automatic t_reset;
    check("config", bus_config_reg, CFG_RESET);
    check("drive", 16'(bus_config_reg[DRIVE_MSB:DRIVE_LSB]), 16'(DRIVE_HALF));
    check("ready", 16'(ready), 16'h1);
  endtask : t_reset
  task automatic t_burst(input logic [2:0] lat);
    int          w;
    int          n;
    logic [15:0] q[$];
    load_cfg({CFG_RESET[15:14], lat, CFG_RESET[10:0]});
    w = 0;
    fork
      m.frame(12, 1'b0);
      repeat (11) begin
        @(negedge m.link_clk);
        if (waitOut === 1'b1) w++;
        if (adqOe === 1'b1) q.push_back(adqOut);
      end
    join
    check("wait cycles", 16'(w), 16'(lat));
    for (n = 0; n < 5; n++) begin
      check("beat", q[n], (n < 4) ? readData : UNDEF_WORD);
    end
  endtask : t_burst
  task automatic t_timeout;
    wait_core(6);
    check("no select timeout", 16'(selectTimeout), 16'h0);
    check("no gap flag", 16'(gapViolation), 16'h0);
    m.frame(20, 1'b1);
    wait_core(6);
    check("select timeout", 16'(selectTimeout), 16'h1);
    check("write timeout", 16'(writeTimeout), 16'h1);
  endtask : t_timeout
  task automatic t_sleep;
    load_cfg(CFG_RESET & ~16'h0010);
    wait_core(32);
    check("early sleep", 16'(deepSleep), 16'h0);
    wait_core(20);
    check("sleep", {15'h0, deepSleep}, 16'h1);
    check("ready in sleep", 16'(ready), 16'h0);
    m.frame(10, 1'b0);
    wait_core(10);
    check("woken", {15'h0, deepSleep}, 16'h0);
    check("ready in wake", 16'(ready), 16'h0);
    wait_core(50);
    check("ready after wake", 16'(ready), 16'h1);
    check("config after wake", bus_config_reg, CFG_RESET);
  endtask : t_sleep
  initial begin
    do_reset();
    t_reset();
    t_burst(3'h2);
    t_burst(3'h4);
    t_timeout();
    do_reset();
    t_sleep();
    test_done();
  end
endmodule : tb
